// ===== shared/rtc_regs_pkg.sv
// constants for the timer and clock control/status register block
// assumes an APB slave with 32-bit data, 8-bit registers in the low byte
package rtc_regs_pkg;
    // ==========================================================
    // register locations (documented indices, byte address = 4x)
    localparam logic [4:0] loc_status   = 5'h00;
    localparam logic [4:0] loc_ctl_one  = 5'h01;
    localparam logic [4:0] loc_ctl_two  = 5'h02;
    localparam logic [4:0] loc_ctl_thr  = 5'h03;
    localparam logic [4:0] loc_ctl_four = 5'h04;
    localparam logic [4:0] loc_test     = 5'h1F;
    localparam int         ram_words    = 31;
    // ==========================================================
    // field positions
    localparam int st_pend = 0;
    localparam int st_pfl  = 1;
    localparam int st_blk  = 6;
    localparam int st_page = 7;
    localparam int tc_run  = 0;
    localparam int tc_rd   = 6;
    localparam int tc_chg  = 7;
    localparam int pf_osc  = 6;
    localparam int pf_test = 7;
    localparam int rt_dly  = 5;
    localparam int rt_bat  = 6;
    localparam int rt_tse  = 7;
    localparam int md_start = 3;
    localparam int md_sby_i = 4;
    localparam int md_sby_t = 5;
    localparam logic [1:0] timer_mode_zero  = 2'h0;
    localparam logic [1:0] timer_mode_three = 2'h3;
    // ==========================================================
    // reset values
    localparam logic [7:0] pf_reset   = 8'h40;
    localparam logic [7:0] zero_byte  = 8'h00;
    localparam logic [31:0] zero_word = 32'h00000000;
    // ==========================================================
    // lockout timing
    localparam int clk_mhz        = 20;
    localparam int delay_long_us  = 480;
    localparam int delay_short_us = 30;
    localparam int delay_long_cyc  = delay_long_us * clk_mhz;
    localparam int delay_short_cyc = delay_short_us * clk_mhz;
    localparam logic [13:0] long_cnt  = 14'(delay_long_cyc);
    localparam logic [13:0] short_cnt = 14'(delay_short_cyc);
endpackage

// ===== src/rtc_control_status_regs.sv
// control and status registers of the timer/clock peripheral, APB slave
// assumes event, comparator and power inputs are asynchronous to pclk
//
// Behaviour
// - status register at location zero, always decoded
// - pending bit mirrors interrupt pins
// - status not cleared by read; write-one clears
// - status set even when source disabled
// - status bits select block and page
// - run bit zero resets timer; mode0 self-clears
// - timer mode and clock source bits
// - read bit latches count, cleared by low read
// - change bit suspends or retriggers timer
// - periodic flags set by rollover, clear on read
// - oscillator flag set at failure, cleared by start
// - test bit enables test register at 1F
// - steering bits route to output or request pin
// - power fail lockout after 480 or 30 us
// - low battery bit follows comparator when enabled
// - time save enable, cleared on power failure
// - leap year counter bits
// - twelve or twenty-four hour select
// - clock start bit held low without oscillator
// - standby without hold clears interrupt enables
// - standby clears timer run bits unless md_sby_t is set
// - crystal select bits, read back as written
// - block select maps registers at 01 to 04
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module rtc_control_status_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  source_events,    // alarm/periodic/timer sources
    input  wire logic [5:0]  rollover_events,
    input  wire logic [1:0]  timer_timeout,
    input  wire logic        power_fail_input, // active high = power good
    input  wire logic        battery_low,
    input  wire logic        osc_running,
    input  wire logic        osc_fail,
    input  wire logic        standby,
    input  wire logic [4:0]  source_enable,
    input  wire logic        power_fail_int_en,
    input  wire logic        year_end,

    // interrupt pins, both from flops
    output logic             interrupt_request_pin,
    output logic             multi_function_output,

    // timer control copies and strobes
    output logic [7:0]       timer0_control,
    output logic [7:0]       timer1_control,
    output logic [1:0]       timer_latch,
    output logic [1:0]       timer_trigger,

    // mode, time save and power fail state
    output logic [7:0]       clock_mode_config,
    output logic             time_save_track,
    output logic             host_locked,
    output logic             standby_clear_enables
);
    // ==========================================================
    // input synchronisers (two flops each)
    // reset to the idle levels: a zero on the power good line would
    // look like a power failure and set the status bit after reset
    localparam int nin = 22;
    localparam logic [nin-1:0] sync_idle = 22'h000100; // power good idles high
    logic [nin-1:0] sync_a, sync_b, sync_q;
    wire  [nin-1:0] raw_in = {source_events, rollover_events, timer_timeout, power_fail_input,
                              battery_low, osc_running, osc_fail, standby, year_end,
                              power_fail_int_en, 1'b0, 1'b0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= sync_idle;
            sync_b <= sync_idle;
            sync_q <= sync_idle;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_q <= sync_b; // one more stage for edge detection
        end
    end
    // levels straight from the second stage
    wire [4:0] ev_src   = sync_b[21:17];

    // edges: second stage against the third
    wire [5:0] ev_roll  = sync_b[16:11] & ~sync_q[16:11];

    wire [1:0] ev_tmo   = sync_b[10:9] & ~sync_q[10:9];

    wire       pf_good  = sync_b[8];

    wire       bat_low  = sync_b[7];

    wire       osc_ok   = sync_b[6];

    wire       osc_bad  = sync_b[5];

    wire       sby      = sync_b[4];

    wire       sby_rise = sync_b[4] & ~sync_q[4];

    wire       yr_end   = sync_b[3] & ~sync_q[3];

    wire       pf_int_en = sync_b[2];

    // ==========================================================
    // register state
    logic [7:0] main_interrupt_status;

    logic [7:0] periodic_event_flags;

    logic [7:0] interrupt_steering;

    logic [7:0] test_reg;

    // second page storage, no reset: software fills it
    logic [7:0] gp_ram [0:rtc_regs_pkg::ram_words-1];

    logic [13:0] lock_cnt;

    logic        lock_run;

    // ==========================================================
    // decode; the status register ignores page and block
    wire [4:0] loc   = paddr[6:2];

    wire       acc   = psel & penable;

    // a locked host neither writes nor clears anything
    wire       wr    = acc & pwrite & ~host_locked;

    wire       rd    = acc & ~pwrite & ~host_locked;

    wire       page1 = main_interrupt_status[rtc_regs_pkg::st_page];

    wire       blk1  = main_interrupt_status[rtc_regs_pkg::st_blk];

    wire       on_p0 = ~page1;

    wire       hit_st  = (loc == rtc_regs_pkg::loc_status);

    wire       hit_t0  = on_p0 & ~blk1 & (loc == rtc_regs_pkg::loc_ctl_one);

    wire       hit_t1  = on_p0 & ~blk1 & (loc == rtc_regs_pkg::loc_ctl_two);

    wire       hit_pf  = on_p0 & ~blk1 & (loc == rtc_regs_pkg::loc_ctl_thr);

    wire       hit_rt  = on_p0 & ~blk1 & (loc == rtc_regs_pkg::loc_ctl_four);

    wire       hit_md  = on_p0 & blk1 & (loc == rtc_regs_pkg::loc_ctl_one);

    wire       hit_ts  = on_p0 & periodic_event_flags[rtc_regs_pkg::pf_test]
                         & (loc == rtc_regs_pkg::loc_test);

    wire       hit_ram = page1 & ~hit_st;

    wire [4:0] ram_ix  = loc - 5'h01;

    wire [7:0] wb      = pwdata[7:0];

    wire       mode_run = clock_mode_config[rtc_regs_pkg::md_start];

    // ==========================================================
    // interrupt status and routing; pending follows the stored status,
    // so a short event on source_events[4:1] still holds the pin until software clears it
    wire [4:0] src_pend = main_interrupt_status[5:1];

    wire [4:0] src_act  = src_pend & source_enable;

    wire [4:0] to_mfo   = src_act & interrupt_steering[4:0];

    wire [4:0] to_irq   = src_act & ~interrupt_steering[4:0];

    wire [4:0] st_set   = {ev_src[4:1], ~pf_good};

    wire [4:0] st_clr   = (wr & hit_st) ? {wb[5:2], 1'b0} : 5'h00;

    // status register: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_interrupt_status <= rtc_regs_pkg::zero_byte;
        end else begin
            main_interrupt_status[5:1] <= st_set | (main_interrupt_status[5:1] & ~st_clr);
            if (pf_good)
                main_interrupt_status[rtc_regs_pkg::st_pfl] <= 1'b0;
            main_interrupt_status[rtc_regs_pkg::st_pend] <= |src_act;
            if (wr & hit_st) begin
                main_interrupt_status[7:6] <= wb[7:6];
            end
        end
    end

    // pins from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request_pin <= 1'b0;
            multi_function_output <= 1'b0;
        end else begin
            interrupt_request_pin <= |to_irq;
            multi_function_output <= |to_mfo;
        end
    end

    // ==========================================================
    // timer control registers
    logic [7:0] tctl [0:1];
    logic [1:0] tlatch, ttrig;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            wire hit   = (g == 0) ? hit_t0 : hit_t1;
            wire twr   = wr & hit;
            wire [1:0] tmode = tctl[g][2:1];
            wire mode0_done = ev_tmo[g] & (tmode == rtc_regs_pkg::timer_mode_zero);
            wire low_read = rd & on_p0 & (loc == (g == 0 ? 5'h0F : 5'h11));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tctl[g]   <= rtc_regs_pkg::zero_byte;
                    tlatch[g] <= 1'b0;
                    ttrig[g]  <= 1'b0;
                end else begin
                    ttrig[g]  <= twr & wb[rtc_regs_pkg::tc_chg]
                                 & (wb[2:1] == rtc_regs_pkg::timer_mode_three);
                    tlatch[g] <= twr & wb[rtc_regs_pkg::tc_rd];
                    if (twr)
                        tctl[g] <= wb;
                    else if (low_read)
                        tctl[g][rtc_regs_pkg::tc_rd] <= 1'b0;
                    if (mode0_done & ~twr)
                        tctl[g][rtc_regs_pkg::tc_run] <= 1'b0;
                    if (sby & ~clock_mode_config[rtc_regs_pkg::md_sby_t] & ~twr)
                        tctl[g][rtc_regs_pkg::tc_run] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_control <= rtc_regs_pkg::zero_byte;
            timer1_control <= rtc_regs_pkg::zero_byte;
            timer_latch    <= 2'h0;
            timer_trigger  <= 2'h0;
        end else begin
            timer0_control <= tctl[0];       // run=0 clears prescaler downstream
            timer1_control <= tctl[1];
            timer_latch    <= tlatch;
            timer_trigger  <= ttrig;
        end
    end

    // ==========================================================
    // periodic flags: rollover set, read clears, osc flag
    wire pf_rd = rd & hit_pf;
    wire start_ok = wr & hit_md & wb[rtc_regs_pkg::md_start] & osc_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periodic_event_flags <= rtc_regs_pkg::pf_reset;
        end else begin
            periodic_event_flags[5:0] <= ev_roll | (pf_rd ? 6'h00 : periodic_event_flags[5:0]);
            if (osc_bad)
                periodic_event_flags[rtc_regs_pkg::pf_osc] <= 1'b1;
            else if (wr & hit_pf)
                periodic_event_flags[rtc_regs_pkg::pf_osc] <= wb[rtc_regs_pkg::pf_osc];
            else if (start_ok)
                periodic_event_flags[rtc_regs_pkg::pf_osc] <= 1'b0;
            if (wr & hit_pf)
                periodic_event_flags[rtc_regs_pkg::pf_test] <= wb[rtc_regs_pkg::pf_test];
        end
    end

    // test register, only reachable while test bit set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            test_reg <= rtc_regs_pkg::zero_byte;
        else if (wr & hit_ts)
            test_reg <= wb;
    end

    // ==========================================================
    // steering register; D6 is a live comparator view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_steering <= rtc_regs_pkg::zero_byte;
        end else begin
            if (wr & hit_rt) begin
                interrupt_steering[5:0] <= wb[5:0];
                interrupt_steering[rtc_regs_pkg::rt_tse] <= wb[rtc_regs_pkg::rt_tse];
            end
            interrupt_steering[rtc_regs_pkg::rt_bat] <= bat_low & pf_int_en;
            if (~pf_good)
                interrupt_steering[rtc_regs_pkg::rt_tse] <= 1'b0;
        end
    end

    // lockout timer: count from power fail, length from delay bit
    wire dly_en = interrupt_steering[rtc_regs_pkg::rt_dly];
    wire [13:0] lock_lim = dly_en ? rtc_regs_pkg::long_cnt : rtc_regs_pkg::short_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt    <= 14'h0000;
            host_locked <= 1'b0;
        end else if (pf_good) begin
            lock_cnt    <= 14'h0000;
            host_locked <= 1'b0;
        end else if (!host_locked) begin
            lock_cnt <= lock_cnt + 14'h0001;
            if (lock_cnt >= lock_lim)
                host_locked <= 1'b1;
        end
    end

    // ==========================================================
    // mode register, standby enable clear, leap year count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_mode_config <= rtc_regs_pkg::zero_byte;
        end else begin
            if (wr & hit_md)
                clock_mode_config <= wb;
            else if (yr_end & mode_run)
                clock_mode_config[1:0] <= clock_mode_config[1:0] + 2'h1;
            if (osc_bad | ~osc_ok)
                clock_mode_config[rtc_regs_pkg::md_start] <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_clear_enables <= 1'b0;
            time_save_track       <= 1'b0;
        end else begin
            standby_clear_enables <= sby_rise & ~clock_mode_config[rtc_regs_pkg::md_sby_i];
            time_save_track       <= interrupt_steering[rtc_regs_pkg::rt_tse];
        end
    end

    // general purpose page
    always_ff @(posedge pclk) begin
        if (wr & hit_ram)
            gp_ram[ram_ix] <= wb;
    end

    // ==========================================================
    // read mux; D2 of mode is 12/24 select, stored as written
    wire [7:0] rd_byte =
        hit_st  ? main_interrupt_status :
        hit_ram ? gp_ram[ram_ix] :
        hit_t0  ? tctl[0] :
        hit_t1  ? tctl[1] :
        hit_pf  ? periodic_event_flags :
        hit_rt  ? interrupt_steering :
        hit_md  ? clock_mode_config :
        hit_ts  ? test_reg : rtc_regs_pkg::zero_byte;
    // single wait-free access phase; writes to read-only bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= rtc_regs_pkg::zero_word;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & host_locked;
            prdata  <= {24'h000000, rd_byte};
        end
    end
endmodule // rtc_control_status_regs

// ===== tb/apb_host.sv
// host processor model: issues one bus transfer for each go request
// assumes the slave raises pready; no fixed answer time is assumed
`timescale 1ns/1ns
module apb_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata
);
    // ==========================================
    // sequencer: setup, access held until pready is sampled high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 32'h00000000;
            pwdata  <= 32'h00000000;
            rdata   <= 32'h00000000;
            done    <= 1'b0;
        end else if (psel && penable && pready) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwdata  <= ~pwdata;  // released data must not keep its value
            rdata   <= prdata;
            done    <= 1'b1;
        end else if (psel) begin
            penable <= 1'b1;
        end else begin
            psel    <= go;
            pwrite  <= wr;
            paddr   <= addr;
            pwdata  <= go ? wdata : ~pwdata;
            done    <= 1'b0;
        end
    end
endmodule // apb_host

// ===== tb/rtc_regs_monitor.sv
// checker of the timer/clock control register block, watching its ports only
// assumes it is bound onto the block, one pclk domain, presetn async active low
`timescale 1ns/1ns
module rtc_regs_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        power_fail_input,
    input wire logic        power_fail_int_en,
    input wire logic [4:0]  source_enable,
    input wire logic        interrupt_request_pin,
    input wire logic        multi_function_output,
    input wire logic [1:0]  timer_latch,
    input wire logic [7:0]  clock_mode_config,
    input wire logic        time_save_track,
    input wire logic        host_locked
);
    // ==========================================
    // properties; all on pclk, quiet during reset
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    answer_next_a: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above the low byte not zero");
    latch_pulse_a: assert property (timer_latch[0] |=> !timer_latch[0])
        else $error("latch pulse longer than one cycle");
    crystal_write_a: assert property ($changed(clock_mode_config[7:6]) |-> $past(psel && penable && pwrite))
        else $error("crystal select changed without a write");
    save_clear_a: assert property ($fell(power_fail_input) |-> ##[1:6] !time_save_track)
        else $error("time save not cleared by power failure");
    lock_early_a: assert property ($fell(power_fail_input) |=> !host_locked [*8])
        else $error("host locked out too early");
    lock_cause_a: assert property ($rose(host_locked) |-> !power_fail_input)
        else $error("lockout while power good");
    pins_quiet_a: assert property ((source_enable == 5'h00 && !power_fail_int_en) [*3]
        |-> !interrupt_request_pin && !multi_function_output)
        else $error("interrupt pin active with all sources disabled");
endmodule // rtc_regs_monitor

bind rtc_control_status_regs rtc_regs_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .power_fail_input, .power_fail_int_en, .source_enable, .interrupt_request_pin, .multi_function_output,
    .timer_latch, .clock_mode_config, .time_save_track, .host_locked);

// ===== tb/tb.sv
// self-checking bench of the timer/clock control register block
// assumes the host model drives the bus and the monitor is bound to the block
`timescale 1ns/1ns
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, wr, done;
    logic [31:0] paddr, pwdata, prdata, addr, wdata, rdata, r;
    logic [4:0]  source_events, source_enable, lc;
    logic [5:0]  rollover_events;
    logic [1:0]  timer_timeout, timer_latch, timer_trigger;
    logic        power_fail_input, battery_low, osc_running, osc_fail, standby, power_fail_int_en, year_end;
    logic        interrupt_request_pin, multi_function_output, time_save_track, host_locked, standby_clear_enables;
    logic [7:0]  timer0_control, timer1_control, clock_mode_config, b;
    int          bad_count = 0, comparisons = 0, cycles = 0, t0;

    rtc_control_status_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .source_events, .rollover_events, .timer_timeout, .power_fail_input, .battery_low, .osc_running,
        .osc_fail, .standby, .source_enable, .power_fail_int_en, .year_end, .interrupt_request_pin,
        .multi_function_output, .timer0_control, .timer1_control, .timer_latch, .timer_trigger, .clock_mode_config,
        .time_save_track, .host_locked, .standby_clear_enables);
    apb_host host_u (.pclk, .presetn, .go, .wr, .addr, .wdata, .done, .rdata, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata);

    // ==========================================
    // clock and hang ceiling, about twenty times the expected run length
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // ==========================================
    // verdict, comparison and bus tasks
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // byte address is four times the location; waits only on done, bounded
    task automatic bus(input logic w, input logic [4:0] loc, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        go <= 1'b1;
        wr <= w;
        addr <= {25'h0000000, loc, 2'h0};
        wdata <= {24'h000000, d};
        @(posedge pclk);
        go <= 1'b0;
        do begin
            @(negedge pclk);
            n++;
        end while (!done && n < 20);
        check("bus answer", 32'(done), 32'h00000001);
        r = rdata;
    endtask
    task automatic rd(input logic [4:0] loc, input logic [7:0] e, input string what);
        bus(1'b0, loc, 8'h00);
        check(what, r, {24'h000000, e});
    endtask

    // ==========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        {source_events, rollover_events, timer_timeout, source_enable, addr, wdata} = '0;
        {battery_low, osc_fail, standby, power_fail_int_en, year_end, go, wr} = '0;
        {power_fail_input, osc_running} = 2'h3;
        void'($urandom(32'h8469));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(rtc_regs_pkg::loc_ctl_thr, rtc_regs_pkg::pf_reset, "flags reset");
        rd(rtc_regs_pkg::loc_status, 8'h00, "status reset");
        for (int k = 0; k < 6; k++) begin
            @(posedge pclk) rollover_events <= 6'h01 << k;
            repeat (4) @(negedge pclk);
            @(posedge pclk) rollover_events <= 6'h00;
            rd(rtc_regs_pkg::loc_ctl_thr, (8'h01 << k) | rtc_regs_pkg::pf_reset, "flag set");
            rd(rtc_regs_pkg::loc_ctl_thr, rtc_regs_pkg::pf_reset, "flag cleared by read");
        end
        $display("test periodic flags done");
        bus(1'b1, rtc_regs_pkg::loc_status, 8'h80);
        rd(rtc_regs_pkg::loc_status, 8'h80, "page bit");
        for (int i = 0; i < 8; i++) begin
            lc = 5'($urandom_range(31, 1));
            b = 8'($urandom);
            bus(1'b1, lc, b);
            rd(lc, b, "page one storage");
        end
        bus(1'b1, rtc_regs_pkg::loc_status, 8'h40);
        rd(rtc_regs_pkg::loc_status, 8'h40, "block bit");
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom);
            bus(1'b1, rtc_regs_pkg::loc_ctl_one, b);
            rd(rtc_regs_pkg::loc_ctl_one, b, "mode readback");
            check("mode port", {24'h000000, clock_mode_config}, {24'h000000, b});
        end
        bus(1'b1, rtc_regs_pkg::loc_ctl_one, 8'h08);
        @(posedge pclk) year_end <= 1'b1;
        repeat (4) @(negedge pclk);
        @(posedge pclk) year_end <= 1'b0;
        rd(rtc_regs_pkg::loc_ctl_one, 8'h09, "leap count step");
        bus(1'b1, rtc_regs_pkg::loc_status, 8'h00);
        rd(rtc_regs_pkg::loc_ctl_thr, 8'h00, "oscillator flag cleared by start");
        $display("test selection and mode done");
        @(posedge pclk) source_events <= 5'h02;
        repeat (4) @(negedge pclk);
        @(posedge pclk) source_events <= 5'h00;
        rd(rtc_regs_pkg::loc_status, 8'h04, "status set while disabled");
        rd(rtc_regs_pkg::loc_status, 8'h04, "status kept on read");
        bus(1'b1, rtc_regs_pkg::loc_ctl_four, 8'h02);
        @(posedge pclk) source_enable <= 5'h02;
        repeat (4) @(negedge pclk);
        check("pins steered out", {30'h00000000, interrupt_request_pin, multi_function_output}, 32'h1);
        rd(rtc_regs_pkg::loc_status, 8'h05, "pending bit");
        bus(1'b1, rtc_regs_pkg::loc_ctl_four, 8'h00);
        repeat (4) @(negedge pclk);
        check("pins steered in", {30'h00000000, interrupt_request_pin, multi_function_output}, 32'h2);
        bus(1'b1, rtc_regs_pkg::loc_status, 8'h04);
        repeat (4) @(negedge pclk);
        rd(rtc_regs_pkg::loc_status, 8'h00, "status and pending cleared");
        @(posedge pclk) source_enable <= 5'h00;
        $display("test interrupt status done");
        bus(1'b1, rtc_regs_pkg::loc_ctl_one, 8'h41);
        rd(rtc_regs_pkg::loc_ctl_one, 8'h41, "read bit held");
        check("timer port", {24'h000000, timer0_control}, 32'h41);
        rd(5'h0F, 8'h00, "low byte");
        rd(rtc_regs_pkg::loc_ctl_one, 8'h01, "read bit cleared");
        @(posedge pclk) timer_timeout <= 2'h1;
        repeat (4) @(negedge pclk);
        @(posedge pclk) timer_timeout <= 2'h0;
        rd(rtc_regs_pkg::loc_ctl_one, 8'h00, "mode zero self stop");
        $display("test timer control done");
        bus(1'b1, rtc_regs_pkg::loc_ctl_four, 8'h80);
        @(negedge pclk); // the tracking copy lags the register by one flop
        check("save tracking", 32'(time_save_track), 32'h00000001);
        @(posedge pclk) power_fail_input <= 1'b0;
        t0 = cycles;
        repeat (8) @(negedge pclk);
        check("save frozen", 32'(time_save_track), 32'h00000000);
        rd(rtc_regs_pkg::loc_status, 8'h02, "power fail status");
        while (!host_locked && cycles - t0 < 2000) @(negedge pclk);
        check("lockout delay", 32'(cycles - t0 >= rtc_regs_pkg::delay_short_cyc
            && cycles - t0 <= 63 * rtc_regs_pkg::clk_mhz), 32'h00000001);
        $display("test power fail done");
        conclude();
    end
endmodule // tb
